/* File: logic/ttc_pkg.sv */
package ttc_pkg;
    // field widths
    localparam int RATIO_W = 8;
    localparam int VID_W = 8;
    localparam int SENS_W = 4;
    // reset values of the applied and requested settings
    localparam logic [7:0] RATIO_RST = 8'h20;
    localparam logic [7:0] VID_RST = 8'h40;
    // ratio steps removed while hot, and the lowest ratio throttling goes to
    localparam logic [7:0] THROTTLE_STEP = 8'h08;
    localparam logic [7:0] RATIO_MIN = 8'h04;
    // reference clock multiplied by the ratio gives core frequency in MHz
    localparam logic [7:0] REF_MHZ = 8'h64;
    // time the core clock generator needs to settle after a change
    localparam int SETTLE_NS = 500;
    localparam int CLK_NS = 20;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_W = 6;
    // interrupt source lines toward the system agent interrupt controller
    localparam int IRQ_W = 4;
    localparam int IRQ_THERMAL = 0;
    localparam int IRQ_DMA = 1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_DONE
    } ttc_apply_type;
endpackage : ttc_pkg

/* File: logic/ttc_sync.sv */
`timescale 1ns/10ps
// two-stage synchroniser; the first stage feeds only the second
module ttc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstSync_n,
    // data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;

    // metastability filter
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule : ttc_sync

/* File: logic/ttc_thermal_throttle_control.sv */
`timescale 1ns/10ps
// Behaviour
// - while thermal event active, hardware lowers the core frequency ratio.
// - monitor never changes voltage itself; only software requests do.
// - thermal event raises interrupt to controller with status and clear.
// - settings written during an event are held and applied afterwards.
// - a done pulse and sticky flag show a change took effect.
// - current core frequency is readable for per-thread timer calibration.
// - interrupt controller lines come only from system agent sources.
module ttc_thermal_throttle_control (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // thermal sensors, one event line each
    input wire logic [ttc_pkg::SENS_W-1:0] sensorHot,
    // software settings request, one-cycle write strobe
    input wire logic reqWrite,
    input wire logic [ttc_pkg::RATIO_W-1:0] reqRatio,
    input wire logic [ttc_pkg::VID_W-1:0] reqVid,
    // software status access
    input wire logic thermalIntEnable,
    input wire logic thermalClear,
    // other system agent interrupt source
    input wire logic dmaIrq,
    // clock generator and voltage regulator controls
    output logic [ttc_pkg::RATIO_W-1:0] coreRatio,
    output logic [ttc_pkg::VID_W-1:0] coreVid,
    // status toward software
    output logic thermalActive,
    output logic thermalStatus,
    output logic changePending,
    output logic changeDone,
    output logic changeDoneFlag,
    output logic [15:0] coreFreqMhz,
    // interrupt controller inputs
    output logic [ttc_pkg::IRQ_W-1:0] ioIrq
);
    // synchronised reset, sensor and settings state
    logic rstMeta_n;
    logic rstSync_n;
    logic [ttc_pkg::SENS_W-1:0] hotSync;
    logic hot;
    logic hotPrev;
    logic [ttc_pkg::RATIO_W-1:0] setRatio;
    logic [ttc_pkg::VID_W-1:0] setVid;
    logic [ttc_pkg::RATIO_W-1:0] pendRatio;
    logic [ttc_pkg::VID_W-1:0] pendVid;
    logic pendValid;
    logic [ttc_pkg::SETTLE_W-1:0] settleCount;
    ttc_pkg::ttc_apply_type state;
    ttc_pkg::ttc_apply_type next_state;
    logic [ttc_pkg::RATIO_W-1:0] next_ratio;
    logic applyNow;

    // throttled ratio, floored so the core never stops
    function automatic logic [ttc_pkg::RATIO_W-1:0] throttled(
        input logic [ttc_pkg::RATIO_W-1:0] r);
        if (r > ttc_pkg::THROTTLE_STEP + ttc_pkg::RATIO_MIN)
            throttled = r - ttc_pkg::THROTTLE_STEP;
        else
            throttled = ttc_pkg::RATIO_MIN;
    endfunction : throttled

    // reset release through two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // sensors are asynchronous to this clock
    ttc_sync #(.W(ttc_pkg::SENS_W)) uSync (
        .clock(clock),
        .rstSync_n(rstSync_n),
        .din(sensorHot),
        .dout(hotSync)
    );

    // any single sensor line is enough to count as hot
    assign hot = |hotSync;

    // event edge tracking
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            hotPrev <= 1'b0;
            thermalActive <= 1'b0;
        end else begin
            hotPrev <= hot;
            thermalActive <= hot;
        end
    end

    // software request held while hot; latest write wins
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            setRatio <= ttc_pkg::RATIO_RST;
            setVid <= ttc_pkg::VID_RST;
            pendRatio <= ttc_pkg::RATIO_RST;
            pendVid <= ttc_pkg::VID_RST;
            pendValid <= 1'b0;
        end else begin
            if (reqWrite) begin
                pendRatio <= reqRatio;
                pendVid <= reqVid;
            end
            if (reqWrite)
                pendValid <= 1'b1;
            else if (applyNow)
                pendValid <= 1'b0;
            if (applyNow) begin
                setRatio <= pendRatio;
                setVid <= pendVid;
            end
        end
    end

    // apply only outside an event, and only from idle
    // waiting for idle keeps every applied change paired with its own done
    assign applyNow = pendValid && !hot && !reqWrite
        && state == ttc_pkg::ST_IDLE;

    // applied ratio: throttled when hot, else the software setting
    always_comb begin
        next_ratio = hot ? throttled(setRatio) : setRatio;
    end

    // clock and voltage outputs; voltage tracks only software values
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            coreRatio <= ttc_pkg::RATIO_RST;
            coreVid <= ttc_pkg::VID_RST;
            coreFreqMhz <= 16'h0000;
        end else begin
            coreRatio <= next_ratio;
            coreVid <= setVid;
            // widen before the product so no frequency bits are lost
            coreFreqMhz <= 16'(next_ratio) * 16'(ttc_pkg::REF_MHZ);
        end
    end

    // settle sequencer, ends with a done indication
    always_comb begin
        next_state = state;
        case (state)
            ttc_pkg::ST_IDLE: begin
                if (applyNow)
                    next_state = ttc_pkg::ST_SETTLE;
            end
            ttc_pkg::ST_SETTLE: begin
                if (settleCount == ttc_pkg::SETTLE_W'(ttc_pkg::SETTLE_CYC - 1))
                    next_state = ttc_pkg::ST_DONE;
            end
            ttc_pkg::ST_DONE: begin
                next_state = ttc_pkg::ST_IDLE;
            end
            default: begin
                next_state = ttc_pkg::ST_IDLE;
            end
        endcase
    end

    // sequencer state and settle counter
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= ttc_pkg::ST_IDLE;
            settleCount <= '0;
        end else begin
            state <= next_state;
            if (state == ttc_pkg::ST_SETTLE)
                settleCount <= settleCount + 1'b1;
            else
                settleCount <= '0;
        end
    end

    // feedback: pulse plus sticky flag; a new completion beats the clear
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            changeDone <= 1'b0;
            changeDoneFlag <= 1'b0;
            changePending <= 1'b0;
        end else begin
            changeDone <= (next_state == ttc_pkg::ST_DONE);
            if (next_state == ttc_pkg::ST_DONE)
                changeDoneFlag <= 1'b1;
            else if (reqWrite)
                changeDoneFlag <= 1'b0;
            // pending covers the write cycle, the wait and the whole settle
            changePending <= (pendValid && !applyNow) || reqWrite
                || next_state == ttc_pkg::ST_SETTLE;
        end
    end

    // sticky thermal status on event onset; set wins over clear
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            thermalStatus <= 1'b0;
        end else if (hot && !hotPrev) begin
            thermalStatus <= 1'b1;
        end else if (thermalClear) begin
            thermalStatus <= 1'b0;
        end
    end

    // interrupt controller lines, all from internal agent sources
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ioIrq <= '0;
        end else begin
            // unused lines are held low so no stray source appears
            ioIrq <= '0;
            ioIrq[ttc_pkg::IRQ_THERMAL] <= thermalIntEnable
                && (thermalStatus || (hot && !hotPrev));
            ioIrq[ttc_pkg::IRQ_DMA] <= dmaIrq;
        end
    end
endmodule : ttc_thermal_throttle_control

/* File: tb/ttc_sensor_model.sv */
`timescale 1ns/10ps
// sensor lines are raw and land mid-cycle, away from any clock edge
module ttc_sensor_model (
    // bench control
    input wire logic heat,
    input wire logic [1:0] lane,
    // sensor event lines
    output logic [3:0] sensorHot
);
    // one line at a time, so each lane is seen to count on its own
    assign #7 sensorHot = heat ? 4'h1 << lane : 4'h0;
endmodule : ttc_sensor_model

/* File: tb/ttc_chk.sv */
`timescale 1ns/10ps
module ttc_chk (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // inputs
    input wire logic [3:0] sensorHot,
    input wire logic reqWrite,
    input wire logic [7:0] reqRatio,
    input wire logic [7:0] reqVid,
    input wire logic thermalIntEnable,
    input wire logic thermalClear,
    input wire logic dmaIrq,
    // outputs
    input wire logic [7:0] coreRatio,
    input wire logic [7:0] coreVid,
    input wire logic thermalActive,
    input wire logic thermalStatus,
    input wire logic changePending,
    input wire logic changeDone,
    input wire logic changeDoneFlag,
    input wire logic [15:0] coreFreqMhz,
    input wire logic [3:0] ioIrq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [2:0] upCnt;
    // edges since release; outputs lag the synchronised reset copy
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            upCnt <= 3'h0;
        else if (upCnt != 3'h5)
            upCnt <= upCnt + 3'h1;
    end
    sequence s_start;
        $rose(changePending) && !thermalActive;
    endsequence
    sequence s_settle;
        ##[1:26] (changeDone || thermalActive);
    endsequence
    a_volt_only_sw: assert property (
        $changed(coreVid) |-> !thermalActive) else $error("vid moved hot");
    a_throttle_step: assert property ($rose(thermalActive) |->
        coreRatio == ($past(coreRatio) >= 8'h0c ?
        $past(coreRatio) - 8'h08 : 8'h04)) else $error("bad throttle");
    a_freq_track: assert property (upCnt == 3'h5 |->
        coreFreqMhz == 16'(coreRatio) * 16'h0064) else $error("bad freq");
    a_irq_map: assert property (upCnt == 3'h5 |->
        ioIrq[1] == $past(dmaIrq) && ioIrq[3:2] == 2'h0)
        else $error("bad irq lines");
    a_status_hold: assert property (
        thermalStatus && !thermalClear |=> thermalStatus)
        else $error("status lost");
    a_hot_flag: assert property (
        $rose(thermalActive) |-> thermalStatus) else $error("no status");
    a_done_bound: assert property (
        s_start |-> s_settle) else $error("no done");
    a_done_pulse: assert property (
        changeDone |-> changeDoneFlag ##1 !changeDone)
        else $error("bad done");
endmodule : ttc_chk
bind ttc_thermal_throttle_control ttc_chk u_chk (.*);

/* File: tb/ttc_thermal_throttle_control_tb.sv */
`timescale 1ns/10ps
module ttc_thermal_throttle_control_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic reqWrite = 1'b0;
    logic [7:0] reqRatio = 8'h00;
    logic [7:0] reqVid = 8'h00;
    logic thermalIntEnable = 1'b0;
    logic thermalClear = 1'b0;
    logic dmaIrq = 1'b0;
    logic heat = 1'b0;
    logic [1:0] lane = 2'h0;
    logic [3:0] sensorHot, ioIrq;
    logic [7:0] coreRatio, coreVid, cur = 8'h20, vid = 8'h40;
    logic thermalActive, thermalStatus, changePending, changeDone;
    logic changeDoneFlag, wasHot = 1'b0;
    logic [15:0] coreFreqMhz;
    logic [31:0] doneQ[$];
    logic [7:0] hotQ[$];
    int err_count = 0;
    int compares = 0;
    always #10 clock = ~clock;
    ttc_sensor_model sens (.heat(heat), .lane(lane), .sensorHot(sensorHot));
    ttc_thermal_throttle_control dut (.*);
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic results;
        $display("err_count=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    // note the settled values first, then raise the one-cycle strobe
    task automatic put(input logic [7:0] r, input logic [7:0] v);
        cur = r;
        vid = v;
        doneQ.push_back({r, v, 16'(r) * 16'h0064});
        {reqRatio, reqVid, reqWrite} = {r, v, 1'b1};
        step(1);
        reqWrite = 1'b0;
    endtask : put
    task automatic wait_done;
        for (int i = 0; i < 60 && !changeDoneFlag; i++)
            step(1);
        cmp(32'(changeDoneFlag), 32'h1);
    endtask : wait_done
    // event on one lane, a request held across it, then cool and clear
    task automatic hot(input logic [1:0] l, input logic en);
        logic [7:0] ov;
        logic [7:0] tr;
        ov = vid;
        tr = cur >= 8'h0c ? cur - 8'h08 : 8'h04;
        {thermalIntEnable, lane, heat} = {en, l, 1'b1};
        hotQ.push_back(tr);
        step(6);
        cmp({thermalActive, thermalStatus, ioIrq[0]}, {2'b11, en});
        put(8'h10 + 8'($urandom % 240), 8'($urandom));
        step(30);
        cmp({coreRatio, coreVid, changePending}, {tr, ov, 1'b1});
        heat = 1'b0;
        wait_done;
        thermalClear = 1'b1;
        step(1);
        thermalClear = 1'b0;
        step(2);
        cmp({thermalStatus, ioIrq[0]}, 2'b00);
    endtask : hot
    // results are read at the falling edge, clear of the launch edge
    always @(negedge clock) begin
        wasHot <= thermalActive;
        if (changeDone === 1'b1)
            cmp({coreRatio, coreVid, coreFreqMhz}, doneQ.size() > 0 ?
                doneQ.pop_front() : 'x);
        if (thermalActive === 1'b1 && !wasHot && hotQ.size() > 0)
            cmp(32'(coreRatio), 32'(hotQ.pop_front()));
    end
    initial begin
        step(6000);
        err_count++;
        results;
    end
    initial begin
        void'($urandom(32'he04d));
        step(20);
        rst_n = 1'b1;
        step(5);
        cmp(32'(coreFreqMhz), 32'h0c80);
        for (int i = 0; i < 4; i++) begin
            dmaIrq = 1'($urandom);
            put(8'h10 + 8'($urandom % 240), 8'($urandom));
            wait_done;
            hot(2'(i), 1'(i % 2));
        end
        // second write lands mid-settle: it waits, then gets its own done
        put(8'h10 + 8'($urandom % 240), 8'($urandom));
        step(3);
        put(8'h10 + 8'($urandom % 240), 8'($urandom));
        step(60);
        cmp({changeDoneFlag, changePending, 8'(doneQ.size())},
            {1'b1, 1'b0, 8'h00});
        // lowest ratio: throttling must stop at the floor
        put(8'h0a, 8'h33);
        wait_done;
        hot(2'h3, 1'b1);
        results;
    end
endmodule : ttc_thermal_throttle_control_tb
